/* rtl/hdlc_status_pkg.sv */
package hdlc_status_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] HDLC_EVENT_STATUS_ADDR = 8'hb1;
    localparam logic [7:0] HDLC_INTERRUPT_MASK_ADDR = 8'hb2;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // ****************************************
    // field positions
    // ****************************************
    localparam int TX_MSG_END_BIT = 0;
    localparam int TX_NOT_FULL_BIT = 1;
    localparam int TX_HALF_EMPTY_BIT = 2;
    localparam int RX_NOT_EMPTY_BIT = 3;
    localparam int RX_HALF_FULL_BIT = 4;
    localparam int RX_PKT_START_BIT = 5;
    localparam int RX_PKT_END_BIT = 6;
    localparam logic [7:0] LATCHED_MASK = 8'h61;
    localparam logic [7:0] LEVEL_MASK = 8'h1e;

    // ****************************************
    // fifo geometry
    // ****************************************
    localparam int FIFO_DEPTH = 64;
    localparam int LEVEL_W = 7;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic rx_pkt_start;
        logic rx_pkt_valid_end;
        logic rx_crc_error;
        logic rx_overrun;
        logic rx_abort;
        logic tx_msg_done;
    } hdlc_events_s;

    typedef struct packed {
        logic       cs;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_access_s;
endpackage : hdlc_status_pkg

/* rtl/fifo_level_flags.sv */
`timescale 1ns/1ps
module fifo_level_flags #(
    parameter int DEPTH   = hdlc_status_pkg::FIFO_DEPTH,
    parameter int LEVEL_W = hdlc_status_pkg::LEVEL_W
) (
    input  wire logic [LEVEL_W-1:0] rx_level_i,
    input  wire logic [LEVEL_W-1:0] tx_level_i,
    output logic      [3:0]         level_flags_o
);
    localparam logic [LEVEL_W-1:0] HALF = LEVEL_W'(DEPTH / 2);
    localparam logic [LEVEL_W-1:0] FULL = LEVEL_W'(DEPTH);

    // refused at elaboration: a count of DEPTH must fit the level inputs
    if (DEPTH < 2 || DEPTH >= (1 << LEVEL_W)) begin : g_bad_depth
        $error("fifo depth does not fit the level width");
    end

    // order: rx half full, rx not empty, tx half empty, tx not full
    always_comb begin
        level_flags_o[3] = rx_level_i > HALF;
        level_flags_o[2] = rx_level_i != '0;
        level_flags_o[1] = tx_level_i < HALF;
        level_flags_o[0] = tx_level_i < FULL;
    end
endmodule : fifo_level_flags

/* rtl/hdlc_status_event_register.sv */
`timescale 1ns/1ps
module hdlc_status_event_register #(
    parameter int DEPTH   = hdlc_status_pkg::FIFO_DEPTH,
    parameter int LEVEL_W = hdlc_status_pkg::LEVEL_W
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          ce_i,
    input  wire hdlc_status_pkg::host_access_s host_i,
    input  wire hdlc_status_pkg::hdlc_events_s events_i,
    input  wire logic [LEVEL_W-1:0]            rx_level_i,
    input  wire logic [LEVEL_W-1:0]            tx_level_i,
    output logic      [7:0]                    rdata_o,
    output logic      [7:0]                    hdlc_event_status_o,
    output logic                               int_n_o
);
    logic [7:0] latched;
    logic [7:0] readback;
    logic [7:0] hdlc_interrupt_mask;
    logic [3:0] level_flags;
    logic [7:0] live;
    logic [7:0] set_ev;
    logic       status_wr;
    logic       status_rd;
    logic       mask_wr;
    logic       mask_rd;
    logic [7:0] next_readback;
    logic [7:0] clr_now;

    // ****************************************
    // live status
    // ****************************************
    fifo_level_flags #(
        .DEPTH   (DEPTH),
        .LEVEL_W (LEVEL_W)
    ) u_levels (
        .rx_level_i    (rx_level_i),
        .tx_level_i    (tx_level_i),
        .level_flags_o (level_flags)
    );

    always_comb begin
        set_ev = '0;
        set_ev[hdlc_status_pkg::RX_PKT_END_BIT] = events_i.rx_pkt_valid_end |
            events_i.rx_crc_error | events_i.rx_overrun | events_i.rx_abort;
        set_ev[hdlc_status_pkg::RX_PKT_START_BIT] = events_i.rx_pkt_start;
        set_ev[hdlc_status_pkg::TX_MSG_END_BIT] = events_i.tx_msg_done;
    end

    always_comb begin
        live = latched & hdlc_status_pkg::LATCHED_MASK;
        live[hdlc_status_pkg::RX_HALF_FULL_BIT]  = level_flags[3];
        live[hdlc_status_pkg::RX_NOT_EMPTY_BIT]  = level_flags[2];
        live[hdlc_status_pkg::TX_HALF_EMPTY_BIT] = level_flags[1];
        live[hdlc_status_pkg::TX_NOT_FULL_BIT]   = level_flags[0];
    end

    // ****************************************
    // host decode
    // ****************************************
    always_comb begin
        status_wr = 1'b0;
        status_rd = 1'b0;
        mask_wr   = 1'b0;
        mask_rd   = 1'b0;
        if (host_i.cs && host_i.addr == hdlc_status_pkg::HDLC_EVENT_STATUS_ADDR) begin
            status_wr = host_i.wr;
            status_rd = host_i.rd;
        end else if (host_i.cs && host_i.addr == hdlc_status_pkg::HDLC_INTERRUPT_MASK_ADDR) begin
            mask_wr = host_i.wr;
            mask_rd = host_i.rd;
        end
    end

    // bit 7 dropped: a one written there by the host has no effect
    always_comb begin
        clr_now = status_wr ? (host_i.wdata & hdlc_status_pkg::LATCHED_MASK) : 8'h00;
        next_readback = readback;
        if (status_wr) begin
            next_readback = (readback & ~host_i.wdata) |
                (live & host_i.wdata & 8'h7f);
        end
    end

    // ****************************************
    // latched events
    // ****************************************
    // set wins over clear so an event in the clearing cycle survives
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            latched <= hdlc_status_pkg::STATUS_RESET;
        end else if (ce_i) begin
            latched <= ((latched & ~clr_now) | set_ev) & hdlc_status_pkg::LATCHED_MASK;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            readback <= hdlc_status_pkg::STATUS_RESET;
        end else if (ce_i) begin
            readback <= next_readback;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hdlc_interrupt_mask <= hdlc_status_pkg::MASK_RESET;
        end else if (ce_i && mask_wr) begin
            hdlc_interrupt_mask <= host_i.wdata & 8'h7f;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            if (status_rd) begin
                rdata_o <= next_readback;
            end else if (mask_rd) begin
                rdata_o <= hdlc_interrupt_mask;
            end else begin
                rdata_o <= 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hdlc_event_status_o <= 8'h00;
        end else if (ce_i) begin
            hdlc_event_status_o <= live;
        end
    end

    // level bits interrupt while their condition stands; latched ones until cleared
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_n_o <= 1'b1;
        end else if (ce_i) begin
            int_n_o <= ~|(live & hdlc_interrupt_mask);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_pkt_end_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && events_i.rx_crc_error |=> latched[hdlc_status_pkg::RX_PKT_END_BIT])
        else $error("packet end not latched on crc error");
    chk_pkt_start_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && events_i.rx_pkt_start |=> latched[hdlc_status_pkg::RX_PKT_START_BIT])
        else $error("packet start not latched");
    chk_rx_half: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> hdlc_event_status_o[4] == ($past(rx_level_i) > LEVEL_W'(DEPTH / 2)))
        else $error("rx half full wrong");
    chk_rx_not_empty: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> hdlc_event_status_o[3] == ($past(rx_level_i) != '0))
        else $error("rx not empty wrong");
    chk_tx_half: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> hdlc_event_status_o[2] == ($past(tx_level_i) < LEVEL_W'(DEPTH / 2)))
        else $error("tx half empty wrong");
    chk_tx_not_full: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> hdlc_event_status_o[1] == ($past(tx_level_i) < LEVEL_W'(DEPTH)))
        else $error("tx not full wrong");
    chk_msg_end_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && events_i.tx_msg_done |=> latched[0] [*2] or
        (latched[0] ##1 $fell(latched[0]))) else $error("message end lost");
    chk_latch_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && status_wr && host_i.wdata[6] && !set_ev[6] |=> !latched[6])
        else $error("packet end not cleared");
    chk_readback_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && status_wr && !host_i.wdata[5] |=> readback[5] == $past(readback[5]))
        else $error("unselected bit changed");
    chk_int_release: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && (live & hdlc_interrupt_mask) == 8'h00 |=> int_n_o)
        else $error("interrupt held without cause");
    chk_bit7_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !readback[7] && !hdlc_event_status_o[7]) else $error("bit 7 set");
    chk_pkt_end_other: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && (events_i.rx_pkt_valid_end || events_i.rx_overrun || events_i.rx_abort)
        |=> latched[hdlc_status_pkg::RX_PKT_END_BIT]) else $error("packet end not latched");
    // an event arriving with its own clear must survive the write
    chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && events_i.tx_msg_done && status_wr && host_i.wdata[0] |=> latched[0])
        else $error("event lost to a clear in the same cycle");
    chk_freeze_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(latched) && $stable(readback) && $stable(rdata_o))
        else $error("state moved while clock enable low");
    chk_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !status_rd && !mask_rd |=> rdata_o == 8'h00)
        else $error("read data not idle");
    chk_int_assert: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && (live & hdlc_interrupt_mask) != 8'h00 |=> !int_n_o)
        else $error("interrupt missing for unmasked cause");
    chk_readback_load: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && status_wr && host_i.wdata[4] |=> readback[4] == $past(live[4]))
        else $error("selected bit not loaded");
    chk_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && mask_wr |=> hdlc_interrupt_mask == ($past(host_i.wdata) & 8'h7f))
        else $error("mask write lost");

    // ****************************************
    // coverage
    // ****************************************
    cov_pkt_end: cover property (@(posedge clk_i) disable iff (rst_i)
        events_i.rx_pkt_valid_end ##2 status_wr ##1 status_rd);
    cov_int: cover property (@(posedge clk_i) disable iff (rst_i) $fell(int_n_o));
    cov_set_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        ce_i && status_wr && set_ev[0] && host_i.wdata[0]);
    cov_freeze: cover property (@(posedge clk_i) disable iff (rst_i)
        !ce_i && events_i.rx_pkt_start);
endmodule : hdlc_status_event_register

/* verification/hdlc_status_event_register_bench.sv */
`timescale 1ns/1ps
module hdlc_status_event_register_bench;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [7:0] ST = hdlc_status_pkg::HDLC_EVENT_STATUS_ADDR;
    localparam logic [7:0] MK = hdlc_status_pkg::HDLC_INTERRUPT_MASK_ADDR;
    typedef struct packed {
        logic [6:0] rx;
        logic [6:0] tx;
        logic [7:0] st;
    } row_s;
    logic                          clk_i;
    logic                          rst_i;
    logic                          ce_i;
    logic                          int_n_o;
    hdlc_status_pkg::host_access_s host_i;
    hdlc_status_pkg::hdlc_events_s events_i;
    logic [6:0]                    rx_level_i;
    logic [6:0]                    tx_level_i;
    logic [7:0]                    rdata_o;
    logic [7:0]                    hdlc_event_status_o;
    logic [7:0]                    exp;
    int                            fail_count;
    int                            comparisons;
    // boundaries of each level threshold, latched bits idle
    row_s rows [6] = '{'{7'h00, 7'h40, 8'h00}, '{7'h01, 7'h3f, 8'h0a}, '{7'h20, 7'h20, 8'h0a},
                       '{7'h21, 7'h1f, 8'h1e}, '{7'h40, 7'h00, 8'h1e}, '{7'h00, 7'h1f, 8'h06}};

    hdlc_status_event_register uut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .host_i(host_i), .events_i(events_i),
        .rx_level_i(rx_level_i), .tx_level_i(tx_level_i), .rdata_o(rdata_o),
        .hdlc_event_status_o(hdlc_event_status_o), .int_n_o(int_n_o));

    // ****************************************
    // tasks
    // ****************************************
    task automatic check8(input logic [7:0] got, input logic [7:0] want);
        comparisons++;
        if (got !== want) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check8

    task automatic check1(input logic got, input logic want);
        comparisons++;
        if (got !== want) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check1

    // write then read back to back; callers keep bit 7 zero
    task automatic wr_rd(input logic [7:0] addr, input logic [7:0] wdata, input logic [7:0] want);
        host_i = '{1'b1, 1'b1, 1'b0, addr, wdata};
        @(negedge clk_i);
        host_i = '{1'b1, 1'b0, 1'b1, addr, 8'h00};
        @(negedge clk_i);
        check8(rdata_o, want);
        host_i = '0;
        // idle edge so the next call never reassigns the strobe in this time step
        @(negedge clk_i);
    endtask : wr_rd

    // one-cycle event, then one more edge for the registered view
    task automatic pulse(input logic [5:0] ev);
        events_i = ev;
        @(negedge clk_i);
        events_i = '0;
        @(negedge clk_i);
    endtask : pulse

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    // ****************************************
    // clock and watchdog
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        repeat (3000) @(posedge clk_i);
        fail_count++;
        close_out();
    end

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        host_i = '0;
        events_i = '0;
        rx_level_i = 7'h00;
        tx_level_i = 7'h00;
        fail_count = 0;
        comparisons = 0;
        repeat (6) @(negedge clk_i);
        check8(hdlc_event_status_o, 8'h00);
        check8(rdata_o, 8'h00);
        check1(int_n_o, 1'b1);
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        foreach (rows[i]) begin
            rx_level_i = rows[i].rx;
            tx_level_i = rows[i].tx;
            repeat (2) @(negedge clk_i);
            check8(hdlc_event_status_o, rows[i].st);
        end
        rx_level_i = 7'h00;
        tx_level_i = 7'h00;
        repeat (2) @(negedge clk_i);
        // every event source; valid end and three receive faults share the packet end bit
        for (int k = 0; k < 6; k++) begin
            exp = (k == 5) ? 8'h20 : ((k == 0) ? 8'h01 : 8'h40);
            pulse(6'(1 << k));
            check8(hdlc_event_status_o, exp | 8'h06);
            // bits written as zero keep what earlier rounds loaded
            wr_rd(ST, exp, (k == 0) ? 8'h01 : ((k == 5) ? 8'h61 : 8'h41));
            check8(hdlc_event_status_o, 8'h06);
        end
        wr_rd(ST, 8'h00, 8'h61);
        wr_rd(ST, 8'h1e, 8'h67);
        wr_rd(ST, 8'h61, 8'h06);
        wr_rd(8'hb3, 8'h55, 8'h00);
        wr_rd(MK, 8'h40, 8'h40);
        check1(int_n_o, 1'b1);
        pulse(6'h02);
        check1(int_n_o, 1'b0);
        pulse(6'h01);
        wr_rd(ST, 8'h40, 8'h46);
        check1(int_n_o, 1'b1);
        wr_rd(ST, 8'h01, 8'h47);
        pulse(6'h20);
        check1(int_n_o, 1'b1);
        wr_rd(ST, 8'h20, 8'h67);
        // frozen clock enable must drop the event entirely
        ce_i = 1'b0;
        pulse(6'h20);
        ce_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check8(hdlc_event_status_o, 8'h06);
        // event and its own clear in one cycle: the event must survive
        events_i = 6'h01;
        host_i = '{1'b1, 1'b1, 1'b0, ST, 8'h01};
        @(negedge clk_i);
        events_i = '0;
        host_i = '0;
        @(negedge clk_i);
        check8(hdlc_event_status_o, 8'h07);
        wr_rd(ST, 8'h01, 8'h67);
        check8(hdlc_event_status_o, 8'h06);
        pulse(6'h04);
        check1(int_n_o, 1'b0);
        rst_i = 1'b1;
        @(negedge clk_i);
        check8(hdlc_event_status_o, 8'h00);
        check1(int_n_o, 1'b1);
        rst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check8(hdlc_event_status_o, 8'h06);
        // level bits interrupt while unmasked and release when the level ends
        wr_rd(MK, 8'h02, 8'h02);
        check1(int_n_o, 1'b0);
        tx_level_i = 7'h40;
        repeat (2) @(negedge clk_i);
        check8(hdlc_event_status_o, 8'h00);
        check1(int_n_o, 1'b1);
        close_out();
    end
endmodule : hdlc_status_event_register_bench
